//--- lceg_regs.svh
// lceg_regs.svh: register offsets, field positions and reset values
// of the legacy processor control block.
// assumes: included by bare name, before any use of the macros.
`ifndef LCEG_REGS_SVH
`define LCEG_REGS_SVH

// register offsets on the 8-bit I/O port space
`define LCEG_OFS_FAST_GATE 8'h92
`define LCEG_OFS_ERR_CLEAR 8'hF0
`define LCEG_OFS_CTRL 8'hF1
`define LCEG_OFS_STATUS 8'hF2

// fast_gate_port fields
`define LCEG_FG_GATE_BIT 1
`define LCEG_FG_RESET 8'h00

// control register fields
`define LCEG_CTRL_REPORT_EN 0
`define LCEG_CTRL_SLEEP 1
`define LCEG_CTRL_MASK 8'h03
`define LCEG_CTRL_RESET 8'h01

// status register fields
`define LCEG_ST_FERR 0
`define LCEG_ST_IRQ 1
`define LCEG_ST_IGN 2
`define LCEG_ST_MASK 3
`define LCEG_ST_SLEEP 4
`define LCEG_ST_KBD 5

// value answered for unmapped or write-only reads
`define LCEG_RD_NONE 8'h00

`endif

//--- lceg_pkg.sv
// lceg_pkg.sv: shared types of the legacy processor control block.
// assumes: compiled before every other file of the block.
package lceg_pkg;

   // one I/O port byte, address or data
   typedef logic [7:0] lceg_byte_t;

   // two-stage synchroniser for a pin level
   typedef logic [1:0] lceg_sync_t;

endpackage : lceg_pkg

//--- lceg_fpu_if.sv
// lceg_fpu_if.sv: signals between the register side and the
// numeric error gate.
// assumes: both ends clocked by the same mclk.
`timescale 1ns/1ps
interface lceg_fpu_if;
   logic ferr_act; // synchronised error, high while active
   logic report_en; // error reporting function enabled
   logic clr_wr; // one-cycle write to the error register
   logic irq_line; // internal request line 13
   logic intr; // registered interrupt to the processor
   logic ign_n; // ignore-error output, active low

   // register side
   modport core (
      output ferr_act,
      output report_en,
      output clr_wr,
      input irq_line,
      input intr,
      input ign_n
   );

   // error gate side
   modport gate (
      input ferr_act,
      input report_en,
      input clr_wr,
      output irq_line,
      output intr,
      output ign_n
   );
endinterface : lceg_fpu_if

//--- lceg_fpu_gate.sv
// lceg_fpu_gate.sv: numeric error request and ignore-error gating.
// assumes: inputs already synchronised to mclk; rst synchronous high.
`timescale 1ns/1ps
module lceg_fpu_gate
   import lceg_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // link to the register side
   lceg_fpu_if.gate fi
);

   logic irq_ff;
   logic intr_ff;
   logic ign_n_ff;
   logic nxt_ign_n;

   assign fi.irq_line = irq_ff;
   assign fi.intr = intr_ff;
   assign fi.ign_n = ign_n_ff;

   // request line 13 follows the active error
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= fi.ferr_act; // see [RULE3]
      end
   end

   // interrupt to the processor once the request is up
   always_ff @(posedge mclk) begin
      if (rst) begin
         intr_ff <= 1'b0;
      end else begin
         intr_ff <= irq_ff; // see [RULE4]
      end
   end

   // ignore-error: set by a write only while the error is active,
   // released with the error or when reporting is off
   always_comb begin
      nxt_ign_n = ign_n_ff;
      if (!fi.report_en || !fi.ferr_act) begin
         nxt_ign_n = 1'b1; // see [RULE5] see [RULE7] see [RULE9]
      end else if (fi.clr_wr) begin
         nxt_ign_n = 1'b0; // see [RULE6]
      end
   end

   // a write with no error falls into the release branch above,
   // so nothing is remembered for later
   always_ff @(posedge mclk) begin
      if (rst) begin
         ign_n_ff <= 1'b1;
      end else begin
         ign_n_ff <= nxt_ign_n; // see [RULE8]
      end
   end

   property p_irq_follow;
      @(posedge mclk) disable iff (rst)
      fi.ferr_act |=> irq_ff;
   endproperty
   a_irq_follow: assert property (p_irq_follow) // see [RULE3]
      else $error("request line not raised on error");

   property p_intr_after_irq;
      @(posedge mclk) disable iff (rst)
      $rose(irq_ff) |-> !intr_ff ##1 intr_ff;
   endproperty
   a_intr_after_irq: assert property (p_intr_after_irq) // see [RULE4]
      else $error("interrupt not one cycle after request");

   property p_ign_needs_err;
      @(posedge mclk) disable iff (rst)
      !ign_n_ff |-> $past(fi.ferr_act) && $past(fi.report_en);
   endproperty
   a_ign_needs_err: assert property (p_ign_needs_err) // see [RULE5]
      else $error("ignore-error driven without error");

   property p_ign_set;
      @(posedge mclk) disable iff (rst)
      fi.clr_wr && fi.ferr_act && fi.report_en |=> !ign_n_ff;
   endproperty
   a_ign_set: assert property (p_ign_set) // see [RULE6]
      else $error("ignore-error not set by write");

   property p_ign_hold;
      @(posedge mclk) disable iff (rst)
      !ign_n_ff && fi.ferr_act && fi.report_en |=> !ign_n_ff;
   endproperty
   a_ign_hold: assert property (p_ign_hold) // see [RULE7]
      else $error("ignore-error dropped while error active");

   property p_no_arm;
      @(posedge mclk) disable iff (rst)
      fi.clr_wr && !fi.ferr_act ##1 fi.ferr_act && !fi.clr_wr
         |=> ign_n_ff;
   endproperty
   a_no_arm: assert property (p_no_arm) // see [RULE8]
      else $error("early write armed ignore-error");

   property p_disabled;
      @(posedge mclk) disable iff (rst)
      !fi.report_en |=> ign_n_ff;
   endproperty
   a_disabled: assert property (p_disabled) // see [RULE9]
      else $error("ignore-error while reporting disabled");

endmodule // lceg_fpu_gate

//--- lceg_top.sv
// lceg_top.sv: legacy processor control block: address mask,
// numeric error request and ignore-error, processor sleep.
// assumes: one 50 MHz mclk, synchronous active-high rst, a port
// master that never waits; pins come from outside the clock.
//
// Functional notes
// [RULE1] address mask output derives from fast gate bit and keyboard gate
// [RULE2] mask asserted when either gate active, negated only when both off
// [RULE3] active error input raises internal request line 13
// [RULE4] raised request then drives the interrupt toward the processor
// [RULE5] ignore-error never asserted unless the error input is active
// [RULE6] error register write while error active asserts ignore-error
// [RULE7] ignore-error stays until the error input is negated
// [RULE8] error register write with no error does nothing, arms nothing
// [RULE9] ignore-error works only while error reporting is enabled
// [RULE10] sleep output is driven and puts the processor to sleep
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "lceg_regs.svh"
module lceg_top
   import lceg_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire lceg_byte_t reg_addr,
   input wire lceg_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output lceg_byte_t reg_rdata,
   // pins from the board
   input wire logic keyboard_gate_in,
   input wire logic fpu_error_in_n,
   // pins to the processor
   output logic addr_bit_mask_out_n,
   output logic ignore_fpu_error_out_n,
   output logic processor_sleep_out_n,
   output logic cpu_intr_out
);

   // decode of one register address against the port
   function automatic logic hit(input lceg_byte_t a, input lceg_byte_t o);
      hit = (a == o);
   endfunction

   // pin synchronisers: stage 0 is read only by stage 1
   lceg_sync_t kbd_sync_ff;
   lceg_sync_t ferr_sync_ff;

   // software visible state
   lceg_byte_t fast_gate_ff;
   lceg_byte_t ctrl_ff;
   lceg_byte_t rdata_ff;
   lceg_byte_t nxt_rdata;
   lceg_byte_t status;

   // pin outputs
   logic mask_n_ff;
   logic sleep_n_ff;

   // decoded write strobes, gate levels and the request line
   logic wr_fast;
   logic wr_clr;
   logic wr_ctrl;
   logic kbd_gate;
   logic fast_gate_bit;
   logic fpu_irq_line;

   lceg_fpu_if fi ();

   // stage the keyboard gate pin into mclk
   always_ff @(posedge mclk) begin
      if (rst) begin
         kbd_sync_ff <= 2'h0;
      end else begin
         kbd_sync_ff <= {kbd_sync_ff[0], keyboard_gate_in};
      end
   end

   // stage the error pin, stored active high
   always_ff @(posedge mclk) begin
      if (rst) begin
         ferr_sync_ff <= 2'h0;
      end else begin
         ferr_sync_ff <= {ferr_sync_ff[0], ~fpu_error_in_n};
      end
   end

   assign kbd_gate = kbd_sync_ff[1];

   // write strobes per register
   assign wr_fast = reg_wr && hit(reg_addr, `LCEG_OFS_FAST_GATE);
   assign wr_clr = reg_wr && hit(reg_addr, `LCEG_OFS_ERR_CLEAR);
   assign wr_ctrl = reg_wr && hit(reg_addr, `LCEG_OFS_CTRL);

   // fast gate port: all eight bits kept, bit 1 steers the mask
   always_ff @(posedge mclk) begin
      if (rst) begin
         fast_gate_ff <= `LCEG_FG_RESET;
      end else if (wr_fast) begin
         fast_gate_ff <= reg_wdata;
      end
   end

   assign fast_gate_bit = fast_gate_ff[`LCEG_FG_GATE_BIT];

   // control: reporting enable and sleep request
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_ff <= `LCEG_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff <= reg_wdata & `LCEG_CTRL_MASK;
      end
   end

   // address mask: either gate asserts it, both off negate it
   always_ff @(posedge mclk) begin
      if (rst) begin
         mask_n_ff <= 1'b1;
      end else begin
         mask_n_ff <= ~(fast_gate_bit | kbd_gate); // see [RULE1] see [RULE2]
      end
   end

   // sleep pin follows the control bit
   always_ff @(posedge mclk) begin
      if (rst) begin
         sleep_n_ff <= 1'b1;
      end else begin
         sleep_n_ff <= ~ctrl_ff[`LCEG_CTRL_SLEEP]; // see [RULE10]
      end
   end

   // hand the error state to the gate
   assign fi.ferr_act = ferr_sync_ff[1];
   assign fi.report_en = ctrl_ff[`LCEG_CTRL_REPORT_EN];
   assign fi.clr_wr = wr_clr; // write data is ignored, only the strobe
   assign fpu_irq_line = fi.irq_line;

   lceg_fpu_gate u_gate (
      .mclk (mclk),
      .rst (rst),
      .fi (fi.gate)
   );

   // status word: live view of the block
   always_comb begin
      status = 8'h00;
      status[`LCEG_ST_FERR] = ferr_sync_ff[1];
      status[`LCEG_ST_IRQ] = fpu_irq_line;
      status[`LCEG_ST_IGN] = ~fi.ign_n;
      status[`LCEG_ST_MASK] = ~mask_n_ff;
      status[`LCEG_ST_SLEEP] = ~sleep_n_ff;
      status[`LCEG_ST_KBD] = kbd_gate;
   end

   // read mux; the error register is write only
   always_comb begin
      nxt_rdata = `LCEG_RD_NONE;
      if (reg_rd) begin
         if (hit(reg_addr, `LCEG_OFS_FAST_GATE)) begin
            nxt_rdata = fast_gate_ff;
         end else if (hit(reg_addr, `LCEG_OFS_CTRL)) begin
            nxt_rdata = ctrl_ff;
         end else if (hit(reg_addr, `LCEG_OFS_STATUS)) begin
            nxt_rdata = status;
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_ff <= `LCEG_RD_NONE;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata = rdata_ff;
   assign addr_bit_mask_out_n = mask_n_ff;
   assign processor_sleep_out_n = sleep_n_ff;
   assign ignore_fpu_error_out_n = fi.ign_n;
   assign cpu_intr_out = fi.intr;

   property p_fast_mask;
      @(posedge mclk) disable iff (rst)
      wr_fast && reg_wdata[`LCEG_FG_GATE_BIT] |=> ##1 !addr_bit_mask_out_n;
   endproperty
   a_fast_mask: assert property (p_fast_mask) // see [RULE1]
      else $error("fast gate write did not assert mask");

   property p_mask_off;
      @(posedge mclk) disable iff (rst)
      !fast_gate_bit && !kbd_gate |=> addr_bit_mask_out_n;
   endproperty
   a_mask_off: assert property (p_mask_off) // see [RULE2]
      else $error("mask asserted with both gates off");

   property p_kbd_mask;
      @(posedge mclk) disable iff (rst)
      kbd_gate |=> !addr_bit_mask_out_n;
   endproperty
   a_kbd_mask: assert property (p_kbd_mask) // see [RULE2]
      else $error("keyboard gate did not assert mask");

   property p_sleep;
      @(posedge mclk) disable iff (rst)
      wr_ctrl |=> ##1
         processor_sleep_out_n == !$past(reg_wdata[`LCEG_CTRL_SLEEP], 2);
   endproperty
   a_sleep: assert property (p_sleep) // see [RULE10]
      else $error("sleep pin does not follow control");

   property p_pin_irq;
      @(posedge mclk) disable iff (rst)
      !fpu_error_in_n [*3] |=> ##1 cpu_intr_out;
   endproperty
   a_pin_irq: assert property (p_pin_irq) // see [RULE4]
      else $error("error pin did not reach interrupt");

   property p_rdata_idle;
      @(posedge mclk) disable iff (rst)
      !reg_rd |=> reg_rdata == `LCEG_RD_NONE;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read slot");

   property p_mask_cause;
      @(posedge mclk) disable iff (rst)
      !addr_bit_mask_out_n |-> $past(fast_gate_bit) || $past(kbd_gate);
   endproperty
   a_mask_cause: assert property (p_mask_cause) // see [RULE2]
      else $error("mask asserted with no gate active");

   property p_fast_hold;
      @(posedge mclk) disable iff (rst)
      !wr_fast |=> $stable(fast_gate_ff);
   endproperty
   a_fast_hold: assert property (p_fast_hold) // see [RULE1]
      else $error("fast gate port changed without a write");

   property p_fast_read;
      @(posedge mclk) disable iff (rst)
      reg_rd && hit(reg_addr, `LCEG_OFS_FAST_GATE) |=>
         reg_rdata == $past(fast_gate_ff);
   endproperty
   a_fast_read: assert property (p_fast_read) // see [RULE1]
      else $error("fast gate port read back wrong");

   property p_ctrl_hold;
      @(posedge mclk) disable iff (rst)
      !wr_ctrl |=> $stable(ctrl_ff);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) // see [RULE9]
      else $error("control changed without a write");

   property p_pin_ign_err;
      @(posedge mclk) disable iff (rst)
      !ignore_fpu_error_out_n |-> !$past(fpu_error_in_n, 3);
   endproperty
   a_pin_ign_err: assert property (p_pin_ign_err) // see [RULE5]
      else $error("ignore-error pin low without error pin");

   property p_pin_ign_release;
      @(posedge mclk) disable iff (rst)
      $past(fpu_error_in_n, 2) |=> ignore_fpu_error_out_n;
   endproperty
   a_pin_ign_release: assert property (p_pin_ign_release) // see [RULE7]
      else $error("ignore-error pin kept after error gone");

   property p_pin_ign_report;
      @(posedge mclk) disable iff (rst)
      !ctrl_ff[`LCEG_CTRL_REPORT_EN] |=> ignore_fpu_error_out_n;
   endproperty
   a_pin_ign_report: assert property (p_pin_ign_report) // see [RULE9]
      else $error("ignore-error pin low with reporting off");

   property p_irq_drop;
      @(posedge mclk) disable iff (rst)
      !fi.ferr_act |=> !fpu_irq_line;
   endproperty
   a_irq_drop: assert property (p_irq_drop) // see [RULE3]
      else $error("request line up with no error");

   property p_intr_cause;
      @(posedge mclk) disable iff (rst)
      cpu_intr_out |-> $past(fpu_irq_line);
   endproperty
   a_intr_cause: assert property (p_intr_cause) // see [RULE4]
      else $error("interrupt with no request before it");

   property p_intr_drop;
      @(posedge mclk) disable iff (rst)
      !fpu_irq_line |=> !cpu_intr_out;
   endproperty
   a_intr_drop: assert property (p_intr_drop) // see [RULE4]
      else $error("interrupt kept after request dropped");

   property p_sleep_on;
      @(posedge mclk) disable iff (rst)
      ctrl_ff[`LCEG_CTRL_SLEEP] |=> !processor_sleep_out_n;
   endproperty
   a_sleep_on: assert property (p_sleep_on) // see [RULE10]
      else $error("sleep pin not driven on request");

   property p_sleep_off;
      @(posedge mclk) disable iff (rst)
      !ctrl_ff[`LCEG_CTRL_SLEEP] |=> processor_sleep_out_n;
   endproperty
   a_sleep_off: assert property (p_sleep_off) // see [RULE10]
      else $error("sleep pin low with no request");

endmodule // lceg_top

//--- lceg_cpu_model.sv
// lceg_cpu_model.sv: processor-side model of the legacy control pins.
// assumes: same mclk as the block; raise_err comes from the bench.
`timescale 1ns/1ps
module lceg_cpu_model (
   // clock
   input wire logic mclk,
   // bench control
   input wire logic raise_err,
   // pins from the block
   input wire logic addr_bit_mask_out_n,
   input wire logic ignore_fpu_error_out_n,
   input wire logic processor_sleep_out_n,
   input wire logic cpu_intr_out,
   // pins to the block and observed state
   output logic fpu_error_in_n,
   output logic cpu_asleep_ff
);
   // error pin driven low while a numeric fault is pending, no delay
   assign fpu_error_in_n = ~raise_err;

   // core drops into sleep one edge after the sleep pin goes low
   always_ff @(posedge mclk) begin
      cpu_asleep_ff <= (processor_sleep_out_n === 1'b0);
   end
endmodule // lceg_cpu_model

//--- legacy_cpu_error_gate_tb_top.sv
// legacy_cpu_error_gate_tb_top.sv: self-checking bench of lceg_top.
// assumes: lceg_pkg, lceg_regs.svh and the cpu model compiled first.
`timescale 1ns/1ps
`include "lceg_regs.svh"
module legacy_cpu_error_gate_tb_top;
   import lceg_pkg::*;

   // bench signals
   logic mclk, rst, reg_wr, reg_rd, keyboard_gate_in, raise_err;
   lceg_byte_t reg_addr, reg_wdata, reg_rdata;
   logic fpu_error_in_n, addr_bit_mask_out_n, ignore_fpu_error_out_n;
   logic processor_sleep_out_n, cpu_intr_out, cpu_asleep_ff;
   int err_total, compares;
   lceg_byte_t fg_val;

   // design under test
   lceg_top dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .keyboard_gate_in(keyboard_gate_in),
      .fpu_error_in_n(fpu_error_in_n),
      .addr_bit_mask_out_n(addr_bit_mask_out_n),
      .ignore_fpu_error_out_n(ignore_fpu_error_out_n),
      .processor_sleep_out_n(processor_sleep_out_n),
      .cpu_intr_out(cpu_intr_out));

   // processor on the far side
   lceg_cpu_model cpu_u (.mclk(mclk), .raise_err(raise_err),
      .addr_bit_mask_out_n(addr_bit_mask_out_n),
      .ignore_fpu_error_out_n(ignore_fpu_error_out_n),
      .processor_sleep_out_n(processor_sleep_out_n),
      .cpu_intr_out(cpu_intr_out), .fpu_error_in_n(fpu_error_in_n),
      .cpu_asleep_ff(cpu_asleep_ff));

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // verdict and end of run
   task automatic complete_run();
      if (err_total == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // compare one byte
   task automatic chk(input lceg_byte_t got, input lceg_byte_t exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // compare one pin level
   task automatic chk_bit(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask

   // let n edges pass, then step past their updates
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // one-cycle register write
   task automatic wr(input lceg_byte_t a, input lceg_byte_t d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // one-cycle read, data checked in the next cycle, then back to 00
   task automatic rd(input lceg_byte_t a, input lceg_byte_t exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      settle(0);
      chk(reg_rdata, exp);
      settle(1);
      chk(reg_rdata, 8'h00);
   endtask

   // pin levels packed as mask, ignore, sleep, intr
   function automatic lceg_byte_t pins();
      return {4'h0, addr_bit_mask_out_n, ignore_fpu_error_out_n,
         processor_sleep_out_n, cpu_intr_out};
   endfunction

   // watchdog well past the expected run length
   initial begin
      repeat (3000) @(posedge mclk);
      err_total++;
      complete_run();
   end

   // main sequence
   initial begin
      err_total = 0;
      compares = 0;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      keyboard_gate_in = 1'b0;
      raise_err = 1'b0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      settle(1);
      chk(pins(), 8'h0E);
      rd(`LCEG_OFS_FAST_GATE, `LCEG_FG_RESET);
      rd(`LCEG_OFS_CTRL, `LCEG_CTRL_RESET);
      rd(`LCEG_OFS_ERR_CLEAR, `LCEG_RD_NONE);
      rd(8'h55, `LCEG_RD_NONE);
      wr(`LCEG_OFS_STATUS, 8'hFF);
      rd(`LCEG_OFS_STATUS, 8'h00);
      // every combination of fast gate bit and keyboard gate
      for (int i = 0; i < 4; i++) begin
         fg_val = 8'hA8;
         fg_val[`LCEG_FG_GATE_BIT] = i[0];
         @(posedge mclk);
         keyboard_gate_in <= i[1];
         wr(`LCEG_OFS_FAST_GATE, fg_val);
         settle(4);
         chk_bit(addr_bit_mask_out_n, ~(i[0] | i[1]));
         rd(`LCEG_OFS_FAST_GATE, fg_val);
      end
      @(posedge mclk);
      keyboard_gate_in <= 1'b0;
      wr(`LCEG_OFS_FAST_GATE, 8'h00);
      settle(4);
      chk_bit(addr_bit_mask_out_n, 1'b1);
      // mask moves on the edge after the write edge, not on it
      wr(`LCEG_OFS_FAST_GATE, 8'h02);
      settle(0);
      chk_bit(addr_bit_mask_out_n, 1'b1);
      settle(1);
      chk_bit(addr_bit_mask_out_n, 1'b0);
      wr(`LCEG_OFS_FAST_GATE, 8'h00);
      settle(3);
      // error register write with no error neither asserts nor arms
      wr(`LCEG_OFS_ERR_CLEAR, 8'h5A);
      settle(2);
      chk_bit(ignore_fpu_error_out_n, 1'b1);
      @(posedge mclk);
      raise_err <= 1'b1;
      settle(3);
      chk_bit(cpu_intr_out, 1'b0);
      settle(1);
      chk_bit(cpu_intr_out, 1'b1);
      chk_bit(ignore_fpu_error_out_n, 1'b1);
      rd(`LCEG_OFS_STATUS, 8'h03);
      wr(`LCEG_OFS_ERR_CLEAR, 8'h00);
      settle(1);
      chk_bit(ignore_fpu_error_out_n, 1'b0);
      settle(10);
      chk_bit(ignore_fpu_error_out_n, 1'b0);
      rd(`LCEG_OFS_STATUS, 8'h07);
      @(posedge mclk);
      raise_err <= 1'b0;
      settle(2);
      chk_bit(ignore_fpu_error_out_n, 1'b0);
      settle(1);
      chk_bit(ignore_fpu_error_out_n, 1'b1);
      settle(1);
      chk_bit(cpu_intr_out, 1'b0);
      // reporting disabled keeps ignore-error negated
      wr(`LCEG_OFS_CTRL, 8'h00);
      @(posedge mclk);
      raise_err <= 1'b1;
      settle(4);
      wr(`LCEG_OFS_ERR_CLEAR, 8'h00);
      settle(2);
      chk_bit(ignore_fpu_error_out_n, 1'b1);
      wr(`LCEG_OFS_CTRL, 8'h01);
      wr(`LCEG_OFS_ERR_CLEAR, 8'h00);
      settle(1);
      chk_bit(ignore_fpu_error_out_n, 1'b0);
      wr(`LCEG_OFS_CTRL, 8'h00);
      settle(2);
      chk_bit(ignore_fpu_error_out_n, 1'b1);
      @(posedge mclk);
      raise_err <= 1'b0;
      settle(4);
      // sleep request and the processor entering sleep
      wr(`LCEG_OFS_CTRL, 8'h03);
      settle(0);
      chk_bit(processor_sleep_out_n, 1'b1);
      settle(1);
      chk_bit(processor_sleep_out_n, 1'b0);
      settle(1);
      chk_bit(cpu_asleep_ff, 1'b1);
      rd(`LCEG_OFS_CTRL, 8'h03);
      rd(`LCEG_OFS_STATUS, 8'h10);
      wr(`LCEG_OFS_CTRL, 8'hFD);
      settle(2);
      chk_bit(processor_sleep_out_n, 1'b1);
      rd(`LCEG_OFS_CTRL, 8'h01);
      complete_run();
   end
endmodule // legacy_cpu_error_gate_tb_top
